/* inc/adc_i2c_pkg.sv */
// Constants, state codes and helpers for the converter's two-wire slave port.
// Assumes sys_clk is the converter clock that the debounce and time-out use.
package adc_i2c_pkg;

  // Own calling address byte, write direction (bit 0 is the direction).
  localparam logic [7:0] DEV_ADDR_BYTE = 8'hd0;

  // Register indices held inside the port.
  localparam logic [7:0] REG_DEBOUNCE_CTRL = 8'h0e;
  localparam logic [7:0] REG_TIMEOUT_CTRL = 8'h10;
  localparam logic [7:0] TIMEOUT_CTRL_RESET = 8'h00;
  localparam logic [1:0] DEBOUNCE_RESET = 2'h0;

  // Field positions.
  localparam int TOC_ENABLE_BIT = 7;
  localparam int TOC_FLAG_BIT = 6;
  localparam int TOC_SEL_MSB = 5;
  localparam int DEB_SEL_LSB = 2;
  localparam int DEB_SEL_MSB = 3;

  // Time-out unit: 32 periods of the converter clock divided by 128.
  localparam int SUBCLOCK_DIV = 128;
  localparam int TIMEOUT_SUBCLOCKS = 32;
  localparam int TIMEOUT_UNIT_CYCLES = SUBCLOCK_DIV * TIMEOUT_SUBCLOCKS;
  // Sixty-four units of 4096 clocks need a nineteenth bit.
  localparam int TIMEOUT_CNT_W = 19;

  // Debounce lengths in converter clocks.
  localparam logic [2:0] DEB_SHORT = 3'h2;
  localparam logic [2:0] DEB_LONG = 3'h4;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_INDEX     = 9'h008,
    ST_INDEX_ACK = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } port_state_type;

  function automatic logic [2:0] debounce_len(input logic [1:0] sel);
    debounce_len = (sel == 2'h0) ? 3'h0 : (sel == 2'h1) ? DEB_SHORT : DEB_LONG;
  endfunction : debounce_len

  function automatic logic is_internal(input logic [7:0] idx);
    is_internal = (idx == REG_TIMEOUT_CTRL) || (idx == REG_DEBOUNCE_CTRL);
  endfunction : is_internal

endpackage : adc_i2c_pkg

/* rtl/line_debouncer.sv */
// Debounce filter for one bus line.
// Assumes the line is already synchronous to sys_clk.
module line_debouncer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Line and filter length in clocks, zero for none
  input wire logic raw_line,
  input wire logic [2:0] filter_len,
  output logic clean_line
);
  import adc_i2c_pkg::*;

  typedef struct packed {
    logic level;
    logic [2:0] cnt;
  } deb_state_type;

  deb_state_type q, d;

  always_comb begin
    d = q;
    if (raw_line == q.level) begin
      d.cnt = 3'h0;
    end else if (filter_len == 3'h0 || q.cnt + 3'h1 >= filter_len) begin
      d.level = raw_line;
      d.cnt = 3'h0;
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  // Idle bus lines are high, so the filter starts high.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{level: 1'b1, cnt: 3'h0};
    end else begin
      q <= d;
    end
  end

  assign clean_line = q.level;

endmodule : line_debouncer

/* rtl/two_entry_buffer.sv */
// Two-entry skid buffer with valid and ready on both sides.
// Assumes the consumer may hold drain_ready low for any time.
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Filling side
  input wire logic fill_valid,
  output logic fill_ready,
  input wire logic [WIDTH-1:0] fill_data,
  // Draining side
  output logic drain_valid,
  input wire logic drain_ready,
  output logic [WIDTH-1:0] drain_data
);
  import adc_i2c_pkg::*;

  typedef struct packed {
    logic main_valid;
    logic [WIDTH-1:0] main_data;
    logic skid_valid;
    logic [WIDTH-1:0] skid_data;
  } buf_state_type;

  buf_state_type q, d;

  always_comb begin
    d = q;
    if (q.main_valid && drain_ready) begin
      d.main_valid = q.skid_valid;
      d.main_data = q.skid_data;
      d.skid_valid = 1'b0;
    end
    if (fill_valid && !q.skid_valid) begin
      if (!d.main_valid) begin
        d.main_valid = 1'b1;
        d.main_data = fill_data;
      end else begin
        d.skid_valid = 1'b1;
        d.skid_data = fill_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Ready only while the skid entry is free, so a full buffer refuses.
  assign fill_ready = !q.skid_valid;
  assign drain_valid = q.main_valid;
  assign drain_data = q.main_data;

endmodule : two_entry_buffer

/* rtl/adc_i2c_slave_regport.sv */
// Two-wire slave register port of the converter module.
// Assumes scl_pin and sda_pin are synchronous to sys_clk, the converter
// clock, and that an outside pull-up resolves the open-drain data line.
//
// Behaviour
// - A write is address, index, data; a read restarts after the index.
// - Only the master makes a start, SDA falling while SCL is high.
// - A matching address is acknowledged in the ninth bit slot.
// - Bytes are eight bits, most significant first, after address ack.
// - The receiver of a byte returns a low acknowledge after bit eight; the port gives none to a write byte that meets a full buffer.
// - The port releases SDA when read data is not acknowledged.
// - Bit 7 of the time-out control register enables the time-out.
// - A time-out sets the bit 6 flag, which stays until written to zero.
// - The period is the 6-bit select plus one times 32 subclocks of 128.
// - The time-out control register is all read-write and resets to zero.
// - Only the fixed device address is answered; others are ignored.
// - A two-bit code selects no, two or four clocks of input debounce.
// - SDA moves only while SCL is low; SDA rising with SCL high is stop.
module adc_i2c_slave_regport #(
  parameter int unsigned TIMEOUT_UNIT = adc_i2c_pkg::TIMEOUT_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Two-wire bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_drive,
  output logic sda_oe,
  // Reads of registers outside the port
  output logic [7:0] reg_index,
  input wire logic [7:0] ext_rd_data,
  // Writes to registers outside the port
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data,
  // Time-out status
  output logic timeout_enable,
  output logic timeout_flag
);
  import adc_i2c_pkg::*;

  default clocking cb_port @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  typedef struct packed {
    port_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] index;
    logic [7:0] toc;
    logic [1:0] deb;
    logic sda_out;
    logic sda_en;
    logic scl_prev;
    logic sda_prev;
    logic [TIMEOUT_CNT_W-1:0] to_cnt;
    logic push;
    logic [7:0] push_data;
  } port_reg_type;

  port_reg_type q, d;
  logic scl_f, sda_f, rise, fall, start, stop, to_hit, buf_ready;
  logic [TIMEOUT_CNT_W-1:0] limit;
  logic [7:0] rd_byte;
  logic [15:0] buf_out;

  line_debouncer u_scl_deb (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .raw_line(scl_pin),
    .filter_len(debounce_len(q.deb)),
    .clean_line(scl_f)
  );

  line_debouncer u_sda_deb (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .raw_line(sda_pin),
    .filter_len(debounce_len(q.deb)),
    .clean_line(sda_f)
  );

  // The buffer lets the outside stall writes without losing a byte.
  two_entry_buffer #(.WIDTH(16)) u_wr_buf (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .fill_valid(q.push),
    .fill_ready(buf_ready),
    .fill_data({q.index, q.push_data}),
    .drain_valid(wr_valid),
    .drain_ready(wr_ready),
    .drain_data(buf_out)
  );

  assign rise = scl_f && !q.scl_prev;
  assign fall = !scl_f && q.scl_prev;
  assign start = scl_f && q.scl_prev && q.sda_prev && !sda_f;
  assign stop = scl_f && q.scl_prev && !q.sda_prev && sda_f;

  assign limit = TIMEOUT_CNT_W'((32'(q.toc[TOC_SEL_MSB:0]) + 32'h0000_0001)
                 * TIMEOUT_UNIT);
  assign to_hit = q.toc[TOC_ENABLE_BIT] && q.state != ST_IDLE
                  && q.to_cnt >= limit - TIMEOUT_CNT_W'(1);

  assign rd_byte = (q.index == REG_TIMEOUT_CTRL) ? q.toc :
                   (q.index == REG_DEBOUNCE_CTRL) ?
                   {4'h0, q.deb, 2'h0} : ext_rd_data;

  always_comb begin
    d = q;
    d.push = 1'b0;
    d.scl_prev = scl_f;
    d.sda_prev = sda_f;
    if (!q.toc[TOC_ENABLE_BIT] || q.state == ST_IDLE || rise || fall) begin
      d.to_cnt = '0;
    end else begin
      d.to_cnt = q.to_cnt + TIMEOUT_CNT_W'(1);
    end
    // shift in most significant bit first
    if (rise && (q.state == ST_ADDR || q.state == ST_INDEX
                 || q.state == ST_WDATA)) begin
      d.shift = {q.shift[6:0], sda_f};
      d.bit_cnt = q.bit_cnt + 4'h1;
    end
    unique case (q.state)
      ST_IDLE: begin
        d.sda_en = 1'b0;
      end
      ST_ADDR: begin
        if (fall && q.bit_cnt == BITS_PER_BYTE) begin
          if (q.shift[7:1] == DEV_ADDR_BYTE[7:1]) begin
            d.sda_en = 1'b1;
            d.rw = q.shift[0];
            d.state = ST_ADDR_ACK;
          end else begin
            d.state = ST_IDLE;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (fall) begin
          d.bit_cnt = 4'h0;
          if (q.rw) begin
            d.shift = rd_byte;
            d.sda_en = !rd_byte[7];
            d.state = ST_RDATA;
          end else begin
            d.sda_en = 1'b0;
            d.state = ST_INDEX;
          end
        end
      end
      ST_INDEX: begin
        if (fall && q.bit_cnt == BITS_PER_BYTE) begin
          d.index = q.shift;
          d.sda_en = 1'b1;
          d.state = ST_INDEX_ACK;
        end
      end
      ST_WDATA: begin
        if (fall && q.bit_cnt == BITS_PER_BYTE) begin
          d.sda_en = 1'b1;
          d.state = ST_WDATA_ACK;
          if (q.index == REG_TIMEOUT_CTRL) begin
            d.toc = q.shift;
          end else if (q.index == REG_DEBOUNCE_CTRL) begin
            d.deb = q.shift[DEB_SEL_MSB:DEB_SEL_LSB];
          end else if (buf_ready) begin
            d.push = 1'b1;
            d.push_data = q.shift;
          end else begin
            // A full buffer answers with no acknowledge.
            d.sda_en = 1'b0;
            d.state = ST_IDLE;
          end
        end
      end
      ST_INDEX_ACK, ST_WDATA_ACK: begin
        if (fall) begin
          d.sda_en = 1'b0;
          d.bit_cnt = 4'h0;
          d.state = ST_WDATA;
        end
      end
      ST_RDATA: begin
        if (rise) begin
          d.bit_cnt = q.bit_cnt + 4'h1;
        end else if (fall) begin
          if (q.bit_cnt == BITS_PER_BYTE) begin
            d.sda_en = 1'b0;
            d.state = ST_RDATA_ACK;
          end else begin
            d.shift = {q.shift[6:0], 1'b0};
            d.sda_en = !q.shift[6];
          end
        end
      end
      ST_RDATA_ACK: begin
        if (rise && sda_f) begin
          d.sda_en = 1'b0;
          d.state = ST_IDLE;
        end else if (fall) begin
          d.bit_cnt = 4'h0;
          d.shift = rd_byte;
          d.sda_en = !rd_byte[7];
          d.state = ST_RDATA;
        end
      end
    endcase
    if (stop) begin
      d.state = ST_IDLE;
      d.sda_en = 1'b0;
    end
    // a start, first or repeated, opens an address byte
    if (start) begin
      d.state = ST_ADDR;
      d.bit_cnt = 4'h0;
      d.sda_en = 1'b0;
    end
    if (to_hit) begin
      d.state = ST_IDLE;
      d.sda_en = 1'b0;
      d.to_cnt = '0;
    end
    // set wins over a software clear
    if (to_hit) begin
      d.toc[TOC_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{state: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00, rw: 1'b0,
             index: 8'h00, toc: TIMEOUT_CTRL_RESET, deb: DEBOUNCE_RESET,
             sda_out: 1'b0, sda_en: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1,
             to_cnt: '0, push: 1'b0, push_data: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign sda_drive = q.sda_out;
  assign sda_oe = q.sda_en;
  assign reg_index = q.index;
  assign wr_index = buf_out[15:8];
  assign wr_data = buf_out[7:0];
  assign timeout_enable = q.toc[TOC_ENABLE_BIT];
  assign timeout_flag = q.toc[TOC_FLAG_BIT];

  // Checks.
  AST_ACK_ON_MATCH: assert property (
    q.state == ST_ADDR && fall && q.bit_cnt == BITS_PER_BYTE
    && q.shift[7:1] == DEV_ADDR_BYTE[7:1] && !start && !stop && !to_hit
    |=> sda_oe && q.state == ST_ADDR_ACK)
    else $error("own address not acknowledged");

  AST_IGNORE_OTHER: assert property (
    q.state == ST_ADDR && fall && q.bit_cnt == BITS_PER_BYTE
    && q.shift[7:1] != DEV_ADDR_BYTE[7:1] && !start
    |=> !sda_oe && q.state == ST_IDLE)
    else $error("foreign address answered");

  AST_START_OPENS: assert property (
    start && !to_hit |=> q.state == ST_ADDR && q.bit_cnt == 4'h0 && !sda_oe)
    else $error("start not detected");

  AST_STOP_IDLE: assert property (
    stop |=> q.state == ST_IDLE && !sda_oe)
    else $error("stop did not free the port");

  AST_NACK_RELEASE: assert property (
    q.state == ST_RDATA_ACK && rise && sda_f |=> !sda_oe ##1 !sda_oe)
    else $error("data line held after no acknowledge");

  AST_MSB_FIRST: assert property (
    q.state == ST_RDATA && fall && q.bit_cnt < BITS_PER_BYTE
    && !start && !stop && !to_hit |=> sda_oe == !$past(q.shift[6]))
    else $error("read bit order wrong");

  AST_BYTE_ACK: assert property (
    q.state == ST_WDATA && fall && q.bit_cnt == BITS_PER_BYTE
    && is_internal(q.index) && !start && !stop && !to_hit
    |=> sda_oe && q.state == ST_WDATA_ACK)
    else $error("received byte not acknowledged");

  AST_FLAG_SET: assert property (
    to_hit |=> timeout_flag && q.state == ST_IDLE && !sda_oe)
    else $error("time-out flag not set");

  AST_COUNT_OFF: assert property (
    !timeout_enable |=> q.to_cnt == '0 || $past(d.toc[TOC_ENABLE_BIT]))
    else $error("time-out counting while disabled");

  AST_PERIOD_BOUND: assert property (
    q.toc[TOC_ENABLE_BIT] && q.state != ST_IDLE |-> q.to_cnt < limit)
    else $error("time-out count passed its period");

  AST_RESET_ZERO: assert property (
    $rose(reset_n) |-> q.toc == TIMEOUT_CTRL_RESET && q.state == ST_IDLE)
    else $error("control register not cleared by reset");

  COV_READ: cover property (@(posedge sys_clk) disable iff (!reset_n)
    q.state == ST_RDATA_ACK ##1 q.state == ST_IDLE);
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (!reset_n)
    q.push);
  COV_TIMEOUT: cover property (@(posedge sys_clk) disable iff (!reset_n)
    to_hit);

endmodule : adc_i2c_slave_regport

/* test/bus_master_model.sv */
// Behavioural two-wire bus master that drives the port's clock and data.
// Assumes the bench resolves the open-drain data line with a pull-up.
module bus_master_model (
  // Clock and resolved data line
  input wire logic sys_clk,
  input wire logic sda_line,
  // Driven levels, high means released
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_i2c_pkg::*;

  // A half phase outlasts the longest debounce plus edge detection.
  localparam int PHASE = 10;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_phase();
    repeat (PHASE) @(posedge sys_clk);
  endtask : wait_phase

  task automatic start();
    wait_phase();
    sda_drv <= 1'b1;
    wait_phase();
    scl <= 1'b1;
    wait_phase();
    sda_drv <= 1'b0;
    wait_phase();
    scl <= 1'b0;
  endtask : start

  task automatic bit_io(input logic b, output logic r);
    wait_phase();
    sda_drv <= b;
    wait_phase();
    scl <= 1'b1;
    wait_phase();
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic ack,
                         output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack, nak);
  endtask : byte_io

  task automatic stop();
    wait_phase();
    sda_drv <= 1'b0;
    wait_phase();
    scl <= 1'b1;
    wait_phase();
    sda_drv <= 1'b1;
  endtask : stop

  // write frame, ended at a missing ack.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] idx,
                           input logic [7:0] data, output logic [2:0] naks);
    logic [7:0] rx;
    naks = 3'h7;
    start();
    byte_io(addr, 1'b1, rx, naks[2]);
    if (naks[2] === 1'b0) begin
      byte_io(idx, 1'b1, rx, naks[1]);
    end
    if (naks[1] === 1'b0) begin
      byte_io(data, 1'b1, rx, naks[0]);
    end
    stop();
  endtask : write_reg

  // read frame; first byte acked, second refused.
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d0,
                          output logic [7:0] d1);
    logic nak;
    logic [7:0] rx;
    start();
    byte_io(DEV_ADDR_BYTE, 1'b1, rx, nak);
    byte_io(idx, 1'b1, rx, nak);
    start();
    byte_io(DEV_ADDR_BYTE | 8'h01, 1'b1, rx, nak);
    byte_io(8'hff, 1'b0, d0, nak);
    byte_io(8'hff, 1'b1, d1, nak);
    stop();
  endtask : read_reg
endmodule : bus_master_model

/* test/tb_top.sv */
// Self-checking bench for the two-wire register port.
// Assumes the bus master model and a pull-up on the data line.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_i2c_pkg::*;

  logic sys_clk, reset_n, scl, sda_drv, sda_line, sda_drive, sda_oe, r;
  logic wr_valid, wr_ready, timeout_enable, timeout_flag;
  logic [7:0] reg_index, ext_rd_data, wr_index, wr_data, v, idx, d0, d1;
  logic [2:0] naks;
  logic [15:0] expq[$];
  logic [15:0] exp_word;
  int bad_count = 0;
  int tests_run = 0;

  assign sda_line = sda_drv & ~(sda_oe & ~sda_drive);

  adc_i2c_slave_regport #(.TIMEOUT_UNIT(4)) u_adc_i2c_slave_regport (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_pin(scl), .sda_pin(sda_line),
    .sda_drive(sda_drive), .sda_oe(sda_oe), .reg_index(reg_index),
    .ext_rd_data(ext_rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_index(wr_index), .wr_data(wr_data),
    .timeout_enable(timeout_enable), .timeout_flag(timeout_flag)
  );

  bus_master_model u_bus_master_model (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] ext_value(input logic [7:0] i);
    ext_value = i ^ 8'h5a;
  endfunction : ext_value

  // Keeps outside traffic away from the two internal indices.
  function automatic logic [7:0] ext_idx(input logic [7:0] i);
    ext_idx = (i == 8'h0e || i == 8'h10) ? 8'h20 : i;
  endfunction : ext_idx

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("bad_count %0d tests_run %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [7:0] i,
                    input logic [7:0] d);
    u_bus_master_model.write_reg(a, i, d, naks);
  endtask : wr

  task automatic rd(input logic [7:0] i);
    u_bus_master_model.read_reg(i, d0, d1);
  endtask : rd

  always @(posedge sys_clk) begin
    ext_rd_data <= ext_value(reg_index);
  end

  // Words handed outside must leave in the order they were written.
  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      exp_word = (expq.size() > 0) ? expq.pop_front() : 16'hxxxx;
      check({8'h00, wr_index, wr_data}, {8'h00, exp_word});
    end
  end

  initial begin
    void'($urandom(25982));
    reset_n = 1'b0;
    wr_ready = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(24'({timeout_enable, timeout_flag}), 24'h00_0000);
    rd(REG_TIMEOUT_CTRL);
    check({8'h00, d0, d1}, {8'h00, {2{TIMEOUT_CTRL_RESET}}});
    for (int c = 0; c < 4; c++) begin
      v = 8'($urandom);
      v[3:2] = c[1:0];
      wr(DEV_ADDR_BYTE, REG_DEBOUNCE_CTRL, v);
      rd(REG_DEBOUNCE_CTRL);
      check({5'h00, naks, d0, d1}, {8'h00, {2{v & 8'h0c}}});
    end
    repeat (6) begin
      v = 8'($urandom) & 8'h7f;
      wr(DEV_ADDR_BYTE, REG_TIMEOUT_CTRL, v);
      rd(REG_TIMEOUT_CTRL);
      check({5'h00, naks, d0, d1}, {8'h00, v, v});
      check(24'({timeout_enable, timeout_flag}), 24'(v[6]));
    end
    idx = v;
    repeat (3) begin
      v = 8'($urandom) & 8'hfe;
      if (v == DEV_ADDR_BYTE) begin
        v = 8'ha0;
      end
      wr(v, REG_TIMEOUT_CTRL, ~idx);
      check(24'(naks), 24'h00_0007);
    end
    rd(REG_TIMEOUT_CTRL);
    check({8'h00, d0, d1}, {8'h00, idx, idx});
    // The third write meets a full buffer while the outside stalls.
    for (int k = 0; k < 3; k++) begin
      idx = ext_idx(8'($urandom));
      v = 8'($urandom);
      if (k < 2) begin
        expq.push_back({idx, v});
      end
      wr(DEV_ADDR_BYTE, idx, v);
      check(24'(naks), (k < 2) ? 24'h00_0000 : 24'h00_0001);
    end
    check(24'(wr_valid), 24'h00_0001);
    repeat (60) begin
      @(posedge sys_clk);
      wr_ready <= 1'($urandom);
    end
    @(posedge sys_clk);
    wr_ready <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(24'(expq.size()), 24'h00_0000);
    check(24'(wr_valid), 24'h00_0000);
    repeat (3) begin
      idx = ext_idx(8'($urandom));
      rd(idx);
      check({8'h00, d0, d1}, {8'h00, {2{ext_value(idx)}}});
      check(24'({sda_drive, sda_oe}), 24'h00_0000);
    end
    wr(DEV_ADDR_BYTE, REG_TIMEOUT_CTRL, 8'h87);
    rd(REG_TIMEOUT_CTRL);
    check({8'h00, d0, d1}, 24'h00_8787);
    check(24'({timeout_enable, timeout_flag}), 24'h00_0002);
    // Clock held low mid-byte: limit is (7 + 1) * 4 clocks here.
    u_bus_master_model.start();
    u_bus_master_model.bit_io(1'b1, r);
    repeat (28) @(posedge sys_clk);
    check(24'(timeout_flag), 24'h00_0000);
    repeat (20) @(posedge sys_clk);
    check(24'({timeout_flag, sda_oe}), 24'h00_0002);
    u_bus_master_model.stop();
    repeat (20) @(posedge sys_clk);
    check(24'(timeout_flag), 24'h00_0001);
    wr(DEV_ADDR_BYTE, REG_TIMEOUT_CTRL, 8'h07);
    check(24'({timeout_enable, timeout_flag}), 24'h00_0000);
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
